// *** pkg/seirq_pkg.sv ***
package seirq_pkg;

    // ------------------------------------------------------------
    // register bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LO_W = 32;
    localparam int HI_W = 16;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MASK_LO = 8'h3C;
    localparam logic [7:0] OFS_MASK_HI = 8'h40;
    localparam logic [7:0] OFS_STAT_LO = 8'h44;
    localparam logic [7:0] OFS_STAT_HI = 8'h48;
    localparam logic [7:0] OFS_CFG = 8'h4C;
    localparam logic [7:0] OFS_PEND_LO = 8'h50;
    localparam logic [7:0] OFS_PEND_HI = 8'h54;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_IRQ_SUMMARY = 0;
    localparam int BIT_PLL_LOCK = 1;
    localparam int BIT_SPI_CRC_ERR = 2;
    localparam int BIT_AUTO_ACK = 3;
    localparam int BIT_TX_BEGIN = 4;
    localparam int BIT_TX_PREAMBLE = 5;
    localparam int BIT_TX_HEADER = 6;
    localparam int BIT_TX_FRAME = 7;
    localparam int BIT_PREAMBLE_REJ = 1;
    localparam int BIT_VOLT_TEMP = 4;
    localparam int BIT_GPIO_EVT = 5;
    localparam int BIT_CIPHER_DONE = 6;
    localparam int BIT_CIPHER_ERR = 7;
    localparam int BIT_CMD_ERR = 8;
    localparam int BIT_HOST_OVF = 9;
    localparam int BIT_HOST_UNF = 10;
    localparam int BIT_HOST_ERR = 11;
    localparam int BIT_CHANNEL_ASSESS_FAIL_FLAG = 12;
    localparam int BIT_CFG_POL = 0;

    // implemented (latching) bits: low 1..29, high 1 and 4..12
    localparam logic [31:0] IMPL_LO = 32'h3FFF_FFFE;
    localparam logic [15:0] IMPL_HI = 16'h1FF2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_STAT_LO = 32'h0000_0000;
    localparam logic [15:0] RST_STAT_HI = 16'h0000;
    localparam logic [31:0] RST_MASK_LO = 32'h0000_0000;
    localparam logic [15:0] RST_MASK_HI = 16'h0000;
    localparam logic RST_POL = 1'b1;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } seirq_req_t;

    typedef struct packed {
        logic [15:0] hi;
        logic [31:0] lo;
    } seirq_evt_t;

endpackage

// *** hdl/seirq_w1c_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

module seirq_w1c_bank #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] IMPL = '1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_set,
    input wire logic i_clr_stb,
    input wire logic [WIDTH-1:0] i_clr_data,
    output logic [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    // ------------------------------------------------------------
    // sticky bits
    // ------------------------------------------------------------
    // set is or-ed after the clear so a fresh event is never lost
    always_comb begin
        q_nxt = q_r;
        if (i_clr_stb) begin
            q_nxt = q_nxt & ~i_clr_data;
        end
        q_nxt = (q_nxt | i_set) & IMPL;
    end

    // storage only, reserved bits stay at zero by the IMPL mask
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_q = q_r;

endmodule

`default_nettype wire

// *** hdl/seirq_top.sv ***
// Operation
// - each event bit latches on its event and holds 1 until cleared
// - only writing one clears an event bit; writing zero leaves it
// - reading status returns current bits with no side effects
// - any set and enabled status bit drives interrupt active
// - with nothing set and enabled the interrupt stays inactive
// - summary flag at bit 0 is read-only, writes never touch it
// - summary flag reads 1 exactly when the interrupt is active
// - interrupt electrical level chosen by a polarity config bit
// - pll lock flag sets on lock, clears only by writing one
// - status is six octets, low word and high half, reset to 0
// - low word layout from summary through bit 29, 30-31 reserved
// - high half layout bits 1 and 4 to 12, rest reserved
// - masked-off events still latch but do not raise interrupt
`timescale 1ns/1ps
`default_nettype none

module seirq_top (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] I_EVT_LO,
    input wire logic [15:0] I_EVT_HI,
    output logic [31:0] O_RDATA,
    output logic O_IRQ,
    output logic O_IRQ_SUMMARY
);

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    // one word per register, full-address compare
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // drive level of the interrupt line from the logical request
    function automatic logic irq_level(input logic req, input logic pol);
        irq_level = pol ? req : ~req;
    endfunction

    seirq_pkg::seirq_req_t req;
    seirq_pkg::seirq_evt_t evt;
    logic [31:0] stat_lo;
    logic [15:0] stat_hi;
    logic [31:0] mask_lo_r;
    logic [31:0] mask_lo_nxt;
    logic [15:0] mask_hi_r;
    logic [15:0] mask_hi_nxt;
    logic pol_r;
    logic pol_nxt;
    logic [31:0] set_lo;
    logic [15:0] set_hi;
    logic clr_lo;
    logic clr_hi;
    logic [31:0] pend_lo;
    logic [15:0] pend_hi;
    logic summary;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic irq_r;
    logic irq_nxt;
    logic sum_r;
    logic sum_nxt;

    assign req = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};
    assign evt = '{hi: I_EVT_HI, lo: I_EVT_LO};

    // ------------------------------------------------------------
    // event capture
    // ------------------------------------------------------------
    // events come from same-clock units, so no synchroniser; bit 0
    // of the low word is never an event input, it is computed
    assign set_lo = evt.lo & seirq_pkg::IMPL_LO;
    assign set_hi = evt.hi & seirq_pkg::IMPL_HI;
    assign clr_lo = req.wr && hit(req.addr, seirq_pkg::OFS_STAT_LO);
    assign clr_hi = req.wr && hit(req.addr, seirq_pkg::OFS_STAT_HI);

    seirq_w1c_bank #(
        .WIDTH(seirq_pkg::LO_W),
        .IMPL(seirq_pkg::IMPL_LO),
        .RST_VAL(seirq_pkg::RST_STAT_LO)
    ) u_bank_lo (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_set(set_lo),
        .i_clr_stb(clr_lo),
        .i_clr_data(req.wdata),
        .o_q(stat_lo)
    );

    seirq_w1c_bank #(
        .WIDTH(seirq_pkg::HI_W),
        .IMPL(seirq_pkg::IMPL_HI),
        .RST_VAL(seirq_pkg::RST_STAT_HI)
    ) u_bank_hi (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_set(set_hi),
        .i_clr_stb(clr_hi),
        .i_clr_data(req.wdata[15:0]),
        .o_q(stat_hi)
    );

    // ------------------------------------------------------------
    // summary of unmasked sources
    // ------------------------------------------------------------
    // masked bits still latch above; they only drop out here
    assign pend_lo = stat_lo & mask_lo_r;
    assign pend_hi = stat_hi & mask_hi_r;
    assign summary = (|pend_lo) | (|pend_hi);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // mask and polarity are plain read/write, reserved bits held at 0
    always_comb begin
        mask_lo_nxt = mask_lo_r;
        mask_hi_nxt = mask_hi_r;
        pol_nxt = pol_r;
        if (req.wr && hit(req.addr, seirq_pkg::OFS_MASK_LO)) begin
            mask_lo_nxt = req.wdata & seirq_pkg::IMPL_LO;
        end
        if (req.wr && hit(req.addr, seirq_pkg::OFS_MASK_HI)) begin
            mask_hi_nxt = req.wdata[15:0] & seirq_pkg::IMPL_HI;
        end
        if (req.wr && hit(req.addr, seirq_pkg::OFS_CFG)) begin
            pol_nxt = req.wdata[seirq_pkg::BIT_CFG_POL];
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            mask_lo_r <= seirq_pkg::RST_MASK_LO;
            mask_hi_r <= seirq_pkg::RST_MASK_HI;
            pol_r <= seirq_pkg::RST_POL;
        end else begin
            mask_lo_r <= mask_lo_nxt;
            mask_hi_r <= mask_hi_nxt;
            pol_r <= pol_nxt;
        end
    end

    // ------------------------------------------------------------
    // interrupt line
    // ------------------------------------------------------------
    // registered so the pin is glitch free; it trails the status bits
    // by one cycle, the summary flag register trails identically
    always_comb begin
        sum_nxt = summary;
        irq_nxt = irq_level(summary, pol_r);
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            sum_r <= 1'b0;
            irq_r <= ~seirq_pkg::RST_POL;
        end else begin
            sum_r <= sum_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // reads have no side effect; unmapped offsets read as zero.
    // the summary bit comes from live logic, never from storage,
    // so no write can clear or set it
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (req.rd) begin
            case (req.addr)
                seirq_pkg::OFS_STAT_LO: begin
                    rdata_nxt = stat_lo;
                    rdata_nxt[seirq_pkg::BIT_IRQ_SUMMARY] = summary;
                end
                seirq_pkg::OFS_STAT_HI: begin
                    rdata_nxt = {16'h0000, stat_hi};
                end
                seirq_pkg::OFS_MASK_LO: begin
                    rdata_nxt = mask_lo_r;
                end
                seirq_pkg::OFS_MASK_HI: begin
                    rdata_nxt = {16'h0000, mask_hi_r};
                end
                seirq_pkg::OFS_CFG: begin
                    rdata_nxt = {31'h0000_0000, pol_r};
                end
                seirq_pkg::OFS_PEND_LO: begin
                    rdata_nxt = pend_lo;
                end
                seirq_pkg::OFS_PEND_HI: begin
                    rdata_nxt = {16'h0000, pend_hi};
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // read data holds only in the cycle after the strobe, zero otherwise
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign O_RDATA = rdata_r;
    assign O_IRQ = irq_r;
    assign O_IRQ_SUMMARY = sum_r;

endmodule

`default_nettype wire

// *** dv/seirq_top_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module seirq_top_chk (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] I_EVT_LO,
    input wire logic [15:0] I_EVT_HI,
    input wire logic [31:0] O_RDATA,
    input wire logic O_IRQ,
    input wire logic O_IRQ_SUMMARY
);
    logic pol_r;
    logic pol_nxt;
    // shadow of the polarity bit, needed to judge the line level
    always_comb begin
        pol_nxt = pol_r;
        if (I_WR && I_ADDR == seirq_pkg::OFS_CFG) begin
            pol_nxt = I_WDATA[seirq_pkg::BIT_CFG_POL];
        end
    end
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            pol_r <= seirq_pkg::RST_POL;
        end else begin
            pol_r <= pol_nxt;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // line level follows summary through the polarity one edge late
    irq_level_a: assert property (O_IRQ == ($past(pol_r) ? O_IRQ_SUMMARY : !O_IRQ_SUMMARY))
        else $error("interrupt line level disagrees with summary");
    sum_read_a: assert property (I_RD && I_ADDR == seirq_pkg::OFS_STAT_LO |=>
        O_RDATA[0] == O_IRQ_SUMMARY) else $error("summary bit disagrees with output");
    rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
        else $error("read data not zero outside answer");
    lo_latch_a: assert property (I_RD && I_ADDR == seirq_pkg::OFS_STAT_LO |=>
        (O_RDATA & $past(I_EVT_LO, 2) & seirq_pkg::IMPL_LO) ==
        ($past(I_EVT_LO, 2) & seirq_pkg::IMPL_LO)) else $error("low event not latched");
    hi_latch_a: assert property (I_RD && I_ADDR == seirq_pkg::OFS_STAT_HI |=>
        (O_RDATA[15:0] & $past(I_EVT_HI, 2) & seirq_pkg::IMPL_HI) ==
        ($past(I_EVT_HI, 2) & seirq_pkg::IMPL_HI)) else $error("high event not latched");
    lo_rsvd_a: assert property (I_RD && I_ADDR == seirq_pkg::OFS_STAT_LO |=>
        O_RDATA[31:30] == 2'h0) else $error("reserved low bits not zero");
    hi_rsvd_a: assert property (I_RD && I_ADDR == seirq_pkg::OFS_STAT_HI |=>
        (O_RDATA & ~{16'h0, seirq_pkg::IMPL_HI}) == 32'h0) else $error("reserved high bits set");
    unmap_rd_a: assert property (I_RD && I_ADDR == 8'h00 |=> O_RDATA == 32'h0)
        else $error("unmapped read not zero");
    cover property (O_IRQ_SUMMARY);
    cover property (I_WR && I_ADDR == seirq_pkg::OFS_STAT_LO);
    cover property ($fell(pol_r));
endmodule
`default_nettype wire

// *** dv/seirq_host_mdl.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// host processor: plain register port master
// ------------------------------------------------------------
module seirq_host_mdl (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    // bus idle from time zero
    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // one-cycle write; data inverted after so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    // one-cycle read; answer only stands in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

// *** dv/system_event_status_irq_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module system_event_status_irq_bench;
    logic clk = 1'b0;
    logic rst, wr, rd, irq, irq_sum;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, evt_lo, d;
    logic [15:0] evt_hi;
    int error_cnt = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    seirq_top dut_u (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .I_EVT_LO(evt_lo), .I_EVT_HI(evt_hi), .O_RDATA(rdata), .O_IRQ(irq),
        .O_IRQ_SUMMARY(irq_sum));
    seirq_host_mdl host_u (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        host_u.rd(a, d);
        chk(d, e);
    endtask
    // one-cycle event pulse
    task automatic ev(input logic [31:0] lo, input logic [15:0] hi);
        @(posedge clk);
        evt_lo <= lo;
        evt_hi <= hi;
        @(posedge clk);
        evt_lo <= 32'h0;
        evt_hi <= 16'h0;
    endtask
    // line lags the registers by one edge; wait three edges before sampling it
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        evt_lo = 32'h0;
        evt_hi = 16'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rc(8'h44, 32'h0);
        rc(8'h48, 32'h0);
        irq_is(1'b0);
        host_u.wr(8'h3C, 32'hFFFFFFFF);
        host_u.wr(8'h40, 32'h0000FFFF);
        // mask keeps only implemented positions, the summary bit is not maskable
        rc(8'h3C, seirq_pkg::IMPL_LO);
        rc(8'h40, {16'h0000, seirq_pkg::IMPL_HI});
        ev(32'h2, 16'h0);
        rc(8'h44, 32'h3);
        irq_is(1'b1);
        chk({31'h0, irq_sum}, 32'h1);
        host_u.wr(8'h44, 32'h1);
        rc(8'h44, 32'h3);
        host_u.wr(8'h44, 32'h0);
        rc(8'h44, 32'h3);
        host_u.wr(8'h44, 32'h2);
        rc(8'h44, 32'h0);
        irq_is(1'b0);
        ev(32'hFFFFFFFF, 16'hFFFF);
        rc(8'h44, 32'h3FFFFFFF);
        rc(8'h48, 32'h00001FF2);
        rc(8'h44, 32'h3FFFFFFF);
        // clears touch only implemented positions, reserved left alone
        host_u.wr(8'h44, 32'h3FFFFFFE);
        host_u.wr(8'h48, 32'h00001FF2);
        rc(8'h44, 32'h0);
        rc(8'h48, 32'h0);
        host_u.wr(8'h3C, 32'h0);
        host_u.wr(8'h40, 32'h0);
        ev(32'h10, 16'h0);
        rc(8'h44, 32'h10);
        irq_is(1'b0);
        host_u.wr(8'h4C, 32'h0);
        rc(8'h4C, 32'h0);
        irq_is(1'b1);
        host_u.wr(8'h3C, 32'h10);
        rc(8'h50, 32'h10);
        irq_is(1'b0);
        host_u.wr(8'h4C, 32'h1);
        host_u.wr(8'h44, 32'h10);
        // event held across the clearing write edge: it must survive
        @(posedge clk);
        evt_lo <= 32'h20;
        host_u.wr(8'h44, 32'h20);
        evt_lo <= 32'h0;
        rc(8'h44, 32'h20);
        rc(8'h00, 32'h0);
        // high half alone must raise the line too, latched low bit 5 masked off (low mask is 0x10)
        host_u.wr(8'h40, 32'h10);
        ev(32'h0, 16'h10);
        rc(8'h54, 32'h10);
        irq_is(1'b1);
        chk({31'h0, irq_sum}, 32'h1);
        rc(8'h44, 32'h21);
        host_u.wr(8'h48, 32'h10);
        irq_is(1'b0);
        // reset in mid-run with bits latched and masks set: all drop to 0
        ev(32'h4, 16'h2);
        rc(8'h48, 32'h2);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rc(8'h44, 32'h0);
        rc(8'h48, 32'h0);
        rc(8'h3C, 32'h0);
        irq_is(1'b0);
        chk({31'h0, irq_sum}, 32'h0);
        give_verdict();
    end
endmodule
bind seirq_top seirq_top_chk chk_u (.*);
`default_nettype wire
